// ---- design/dnp3_link_transport_slave.sv ----
`timescale 1ns/1ps
module dnp3_link_transport_slave #(
  parameter int BIT_CYCLES = dnp3_pkg::BIT_CYCLES,
  parameter int FIFO_DEPTH = dnp3_pkg::FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [15:0] link_addr,
  input wire logic rx_in,
  output logic tx_out,
  output logic tx_oe_n,
  output logic out_valid,
  input wire logic out_ready,
  output dnp3_pkg::seg_byte_type out_item,
  output logic seq_gap,
  output logic frame_drop,
  output logic link_reset,
  output logic user_reset
);
  localparam logic [15:0] FULL = 16'(BIT_CYCLES - 1);
  localparam logic [15:0] HALF = 16'(BIT_CYCLES / 2);

  dnp3_pkg::rx_state_type state;
  logic rx_busy, rx_done, pend, take, push, in_ready, first, sof;
  logic [15:0] rx_cnt, rcrc, dst, src, resp_dst, tcrc;
  logic [3:0] rx_bit, tx_bit, tx_idx, next_idx, resp_func;
  logic [7:0] rx_sh, b, len, ctrl, crc_lo, ucount, tp, tx_byte;
  logic [4:0] blk;
  logic [5:0] last_seq;
  logic [11:0] msg_cnt;
  logic in_msg, resp_arm, resp_set, resp_pend, tx_active, hdr_ok, blk_ok;
  logic [15:0] tx_cnt;
  logic [9:0] tx_sh;
  dnp3_pkg::seg_byte_type item;

  // serial receiver, sampled mid-bit; muted while we drive the line
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_busy <= 1'b0;
      rx_done <= 1'b0;
      rx_cnt <= '0;
      rx_bit <= '0;
      rx_sh <= '0;
    end else begin
      rx_done <= 1'b0;
      if (!rx_busy) begin
        if (!rx_in && !tx_active) begin
          rx_busy <= 1'b1;
          rx_cnt <= HALF;
          rx_bit <= '0;
        end
      end else if (rx_cnt != '0) begin
        rx_cnt <= rx_cnt - 1'b1;
      end else begin
        rx_cnt <= FULL;
        rx_bit <= rx_bit + 1'b1;
        if (rx_bit == 4'h0 && rx_in) begin
          rx_busy <= 1'b0; // glitch, not a start bit
        end else if (rx_bit == 4'h9) begin
          rx_busy <= 1'b0;
          rx_done <= rx_in; // framing error drops the character
        end else if (rx_bit != 4'h0) begin
          rx_sh <= {rx_in, rx_sh[7:1]};
        end
      end
    end
  end

  // one-byte holding stage; a full fifo stalls the parser here
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pend <= 1'b0;
      b <= '0;
    end else if (rx_done) begin
      pend <= 1'b1;
      b <= rx_sh;
    end else if (take) begin
      pend <= 1'b0;
    end
  end

  assign push = pend && state == dnp3_pkg::S_DATA && !first &&
                msg_cnt != dnp3_pkg::FRAG_MAX;
  assign take = pend && !(push && !in_ready);
  assign hdr_ok = ({b, crc_lo} == ~rcrc) && dst == link_addr &&
                  link_addr <= dnp3_pkg::ADDR_MAX && ctrl[dnp3_pkg::CTRL_PRM]
                  && len >= dnp3_pkg::HDR_LEN;
  assign blk_ok = {b, crc_lo} == ~rcrc;
  assign item = '{fir: tp[dnp3_pkg::TP_FIR], fin: tp[dnp3_pkg::TP_FIN],
                  sof: sof, eof: ucount == 8'h01, data: b};

  // link frame parser; length octet caps a frame at 292 octets
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= dnp3_pkg::S_SYNC0;
      rcrc <= '0;
      len <= '0;
      ctrl <= '0;
      dst <= '0;
      src <= '0;
      crc_lo <= '0;
      ucount <= '0;
      blk <= '0;
      first <= 1'b0;
      resp_arm <= 1'b0;
      resp_set <= 1'b0;
      resp_func <= '0;
      resp_dst <= '0;
      frame_drop <= 1'b0;
      link_reset <= 1'b0;
      user_reset <= 1'b0;
    end else begin
      resp_set <= 1'b0;
      frame_drop <= 1'b0;
      link_reset <= 1'b0;
      user_reset <= 1'b0;
      if (take) begin
        case (state)
          dnp3_pkg::S_SYNC0: begin
            rcrc <= dnp3_pkg::crc_step(16'h0000, b);
            if (b == dnp3_pkg::START0) state <= dnp3_pkg::S_SYNC1;
          end
          dnp3_pkg::S_SYNC1: begin
            rcrc <= dnp3_pkg::crc_step(rcrc, b);
            if (b == dnp3_pkg::START1) state <= dnp3_pkg::S_LEN;
            else if (b != dnp3_pkg::START0) state <= dnp3_pkg::S_SYNC0;
            else rcrc <= dnp3_pkg::crc_step(16'h0000, b);
          end
          dnp3_pkg::S_HCRC0, dnp3_pkg::S_DCRC0: begin
            crc_lo <= b;
            state <= (state == dnp3_pkg::S_HCRC0) ? dnp3_pkg::S_HCRC1 :
                     dnp3_pkg::S_DCRC1;
          end
          dnp3_pkg::S_HCRC1: begin
            rcrc <= '0;
            state <= dnp3_pkg::S_SYNC0;
            resp_dst <= src;
            resp_func <= (ctrl[3:0] == dnp3_pkg::FN_LINK_STATUS) ?
                         dnp3_pkg::FN_STATUS : dnp3_pkg::FN_ACK;
            if (!hdr_ok) begin
              frame_drop <= 1'b1; // no answer at all
            end else if ((ctrl[3:0] == dnp3_pkg::FN_CONF_DATA ||
                          ctrl[3:0] == dnp3_pkg::FN_UNCONF_DATA) &&
                         len > dnp3_pkg::HDR_LEN) begin
              ucount <= len - dnp3_pkg::HDR_LEN;
              blk <= (len - dnp3_pkg::HDR_LEN > dnp3_pkg::BLOCK_BYTES) ?
                     5'h10 : 5'(len - dnp3_pkg::HDR_LEN);
              first <= 1'b1;
              resp_arm <= ctrl[3:0] == dnp3_pkg::FN_CONF_DATA;
              state <= dnp3_pkg::S_DATA;
            end else if (len == dnp3_pkg::HDR_LEN &&
                         (ctrl[3:0] == dnp3_pkg::FN_RESET_LINK ||
                          ctrl[3:0] == dnp3_pkg::FN_RESET_USER ||
                          ctrl[3:0] == dnp3_pkg::FN_LINK_STATUS)) begin
              resp_set <= 1'b1;
              link_reset <= ctrl[3:0] == dnp3_pkg::FN_RESET_LINK;
              user_reset <= ctrl[3:0] == dnp3_pkg::FN_RESET_USER;
            end else begin
              frame_drop <= 1'b1;
            end
          end
          dnp3_pkg::S_DATA: begin
            rcrc <= dnp3_pkg::crc_step(rcrc, b);
            first <= 1'b0;
            ucount <= ucount - 1'b1;
            blk <= blk - 1'b1;
            if (!first && !push) frame_drop <= 1'b1;
            if (blk == 5'h01) state <= dnp3_pkg::S_DCRC0;
            else state <= dnp3_pkg::S_DATA;
          end
          dnp3_pkg::S_DCRC1: begin
            rcrc <= '0;
            if (!blk_ok) begin
              frame_drop <= 1'b1;
              state <= dnp3_pkg::S_SYNC0;
            end else if (ucount == 8'h00) begin
              resp_set <= resp_arm;
              state <= dnp3_pkg::S_SYNC0;
            end else begin
              blk <= (ucount > dnp3_pkg::BLOCK_BYTES) ? 5'h10 :
                     5'(ucount);
              state <= dnp3_pkg::S_DATA;
            end
          end
          default: begin
            rcrc <= dnp3_pkg::crc_step(rcrc, b);
            if (state == dnp3_pkg::S_LEN) len <= b;
            if (state == dnp3_pkg::S_CTRL) ctrl <= b;
            if (state == dnp3_pkg::S_DST0) dst[7:0] <= b;
            if (state == dnp3_pkg::S_DST1) dst[15:8] <= b;
            if (state == dnp3_pkg::S_SRC0) src[7:0] <= b;
            if (state == dnp3_pkg::S_SRC1) src[15:8] <= b;
            state <= dnp3_pkg::rx_state_type'(state + 1);
          end
        endcase
      end
    end
  end

  // transport byte: flags, sequence, message length
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tp <= '0;
      sof <= 1'b0;
      last_seq <= '0;
      in_msg <= 1'b0;
      seq_gap <= 1'b0;
      msg_cnt <= '0;
    end else begin
      seq_gap <= 1'b0;
      if (link_reset || user_reset) begin
        in_msg <= 1'b0;
      end else if (take && state == dnp3_pkg::S_DATA && first) begin
        tp <= b;
        sof <= 1'b1;
        last_seq <= b[5:0];
        in_msg <= !b[dnp3_pkg::TP_FIN];
        if (b[dnp3_pkg::TP_FIR]) begin
          msg_cnt <= '0;
        end else if (!(in_msg && b[5:0] == last_seq + 1'b1)) begin
          seq_gap <= 1'b1; // data still forwarded after a gap
        end
      end else if (push && in_ready) begin
        sof <= 1'b0;
        msg_cnt <= msg_cnt + 1'b1;
      end
    end
  end

  seg_fifo #(
    .WIDTH($bits(dnp3_pkg::seg_byte_type)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(in_ready),
    .in_data(item),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_item)
  );

  // answer pending; a new request wins over the start-of-send clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) resp_pend <= 1'b0;
    else if (resp_set) resp_pend <= 1'b1;
    else if (!tx_active) resp_pend <= 1'b0;
  end

  // reply bytes: header with secondary control, then complemented crc
  assign next_idx = tx_active ? tx_idx + 1'b1 : 4'h0;
  always_comb begin
    case (next_idx)
      4'h0: tx_byte = dnp3_pkg::START0;
      4'h1: tx_byte = dnp3_pkg::START1;
      4'h2: tx_byte = dnp3_pkg::HDR_LEN;
      4'h3: tx_byte = {4'h0, resp_func};
      4'h4: tx_byte = resp_dst[7:0];
      4'h5: tx_byte = resp_dst[15:8];
      4'h6: tx_byte = link_addr[7:0];
      4'h7: tx_byte = link_addr[15:8];
      4'h8: tx_byte = ~tcrc[7:0];
      4'h9: tx_byte = ~tcrc[15:8];
      default: tx_byte = 8'hff;
    endcase
  end

  // serial transmitter, starts only on a pending answer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_active <= 1'b0;
      tx_idx <= '0;
      tx_bit <= '0;
      tx_cnt <= '0;
      tx_sh <= 10'h3ff;
      tcrc <= '0;
    end else if (!tx_active ? resp_pend : (tx_cnt == '0 && tx_bit == 4'h9 &&
                 tx_idx != dnp3_pkg::RESP_BYTES - 1'b1)) begin
      tx_active <= 1'b1;
      tx_idx <= next_idx;
      tx_sh <= {1'b1, tx_byte, 1'b0};
      tx_bit <= '0;
      tx_cnt <= FULL;
      if (next_idx < 4'h8)
        tcrc <= dnp3_pkg::crc_step(tx_active ? tcrc : 16'h0000, tx_byte);
    end else if (tx_active) begin
      if (tx_cnt != '0) begin
        tx_cnt <= tx_cnt - 1'b1;
      end else begin
        tx_cnt <= FULL;
        if (tx_bit == 4'h9) begin
          tx_active <= 1'b0; // release the line after the stop bit
        end else begin
          tx_bit <= tx_bit + 1'b1;
          tx_sh <= {1'b1, tx_sh[9:1]};
        end
      end
    end
  end

  assign tx_out = tx_active ? tx_sh[0] : 1'b1;
  assign tx_oe_n = !tx_active;

  // all checks live in the one clock domain, quiet during reset
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  chk_idle_high: assert property (
    tx_oe_n |-> tx_out) else $error("line not idle high");
  chk_tx_reply: assert property (
    $fell(tx_oe_n) |-> $past(resp_pend)) else $error("unasked tx");
  chk_start_bit: assert property (
    $fell(tx_oe_n) |-> !tx_out[*2]) else $error("no start bit");
  chk_addr_match: assert property (
    $rose(link_reset) |-> dst == link_addr) else $error("bad addr");
  // only supported requests are answered, and with the matching code
  chk_func_set: assert property (
    resp_set |-> (ctrl[3:0] == dnp3_pkg::FN_RESET_LINK ||
                  ctrl[3:0] == dnp3_pkg::FN_RESET_USER ||
                  ctrl[3:0] == dnp3_pkg::FN_LINK_STATUS ||
                  ctrl[3:0] == dnp3_pkg::FN_CONF_DATA) &&
    resp_func == ((ctrl[3:0] == dnp3_pkg::FN_LINK_STATUS) ?
                  dnp3_pkg::FN_STATUS : dnp3_pkg::FN_ACK))
    else $error("bad func");
  chk_drop_silent: assert property (
    frame_drop |-> !resp_set ##1 !resp_pend) else $error("drop answered");
  chk_block_len: assert property (
    state == dnp3_pkg::S_DATA |-> blk <= 5'h10 && blk != 5'h00 &&
    ucount != 8'h00) else $error("block size");
  // a byte beyond the fragment limit must be reported, not queued
  chk_frag_limit: assert property (
    take && state == dnp3_pkg::S_DATA && !first &&
    msg_cnt == dnp3_pkg::FRAG_MAX |=> frame_drop) else $error("frag over");
  chk_no_echo: assert property (
    !tx_oe_n |-> !rx_done) else $error("rx while tx");
  chk_fifo_hold: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_item))
    else $error("fifo output moved");
  cov_status: cover property (
    resp_set && resp_func == dnp3_pkg::FN_STATUS);
  cov_seg_end: cover property (push && in_ready && item.eof);
  cov_gap: cover property (seq_gap);
endmodule // dnp3_link_transport_slave

// ---- design/dnp3_pkg.sv ----
package dnp3_pkg;
  // serial timing
  localparam int CLK_HZ = 50_000_000;
  localparam int BAUD_RATE = 9600;
  localparam int BIT_CYCLES = CLK_HZ / BAUD_RATE;
  localparam int FIFO_DEPTH = 16;
  // frame layout
  localparam logic [7:0] START0 = 8'h05;
  localparam logic [7:0] START1 = 8'h64;
  localparam logic [7:0] HDR_LEN = 8'h05;
  localparam logic [7:0] BLOCK_BYTES = 8'h10;
  localparam logic [3:0] RESP_BYTES = 4'ha;
  localparam int CTRL_PRM = 6;
  localparam int TP_FIN = 7;
  localparam int TP_FIR = 6;
  localparam logic [15:0] ADDR_MAX = 16'hfffe;
  localparam logic [11:0] FRAG_MAX = 12'h800;
  localparam logic [15:0] CRC_POLY = 16'ha6bc;
  // primary function codes from the master
  localparam logic [3:0] FN_RESET_LINK = 4'h0;
  localparam logic [3:0] FN_RESET_USER = 4'h1;
  localparam logic [3:0] FN_CONF_DATA = 4'h3;
  localparam logic [3:0] FN_UNCONF_DATA = 4'h4;
  localparam logic [3:0] FN_LINK_STATUS = 4'h9;
  // secondary function codes sent back
  localparam logic [3:0] FN_ACK = 4'h0;
  localparam logic [3:0] FN_STATUS = 4'hb;

  typedef struct packed {
    logic fir;
    logic fin;
    logic sof;
    logic eof;
    logic [7:0] data;
  } seg_byte_type;

  typedef enum {
    S_SYNC0, S_SYNC1, S_LEN, S_CTRL, S_DST0, S_DST1, S_SRC0, S_SRC1,
    S_HCRC0, S_HCRC1, S_DATA, S_DCRC0, S_DCRC1
  } rx_state_type;

  // reflected crc, init zero, sent complemented low byte first
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
endpackage

// ---- design/seg_fifo.sv ----
`timescale 1ns/1ps
module seg_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] count;
  logic wr;
  logic rd;

  // the output register adds one slot beyond the array
  assign in_ready = count != (AW+1)'(DEPTH);
  assign wr = in_valid && in_ready;
  assign rd = (count != '0) && (!out_valid || out_ready);

  // array write side
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wp <= '0;
    end else if (wr) begin
      mem[wp] <= in_data;
      wp <= wp + 1'b1;
    end
  end

  // registered read side
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rp <= '0;
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (rd) begin
      out_data <= mem[rp];
      out_valid <= 1'b1;
      rp <= rp + 1'b1;
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

  // occupancy of the array
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else begin
      count <= count + (AW+1)'(wr) - (AW+1)'(rd);
    end
  end
endmodule // seg_fifo

// ---- verif/dnp3_master_model.sv ----
`timescale 1ns/1ps
module dnp3_master_model #(
  parameter int BIT_CYCLES = 16
) (
  input wire logic mclk,
  input wire logic line_in,
  input wire logic tx_oe_n,
  output logic line_out
);
  logic [7:0] got[$];
  logic stop_bad;

  // idle line is held high by the bus bias, so the master rests at one
  initial begin
    line_out = 1'b1;
    stop_bad = 1'b0;
  end

  // one character: start low, eight bits lsb first, stop high
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] chr;
    chr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge mclk);
      line_out = chr[i];
      repeat (BIT_CYCLES - 1) @(negedge mclk);
    end
  endtask

  // talk only once the slave has let go of the line
  task automatic send_frame(input logic [7:0] q[$]);
    wait (tx_oe_n === 1'b1);
    foreach (q[i]) send_byte(q[i]);
  endtask

  // sample replies mid-bit; our own echo is skipped via the enable
  always begin
    logic [7:0] b;
    @(negedge line_in);
    if (tx_oe_n === 1'b0) begin
      repeat (BIT_CYCLES / 2) @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYCLES) @(posedge mclk);
        b[i] = line_in;
      end
      repeat (BIT_CYCLES) @(posedge mclk);
      if (line_in !== 1'b1) stop_bad = 1'b1;
      got.push_back(b);
    end
  end
endmodule // dnp3_master_model

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  localparam logic [15:0] REQ_SRC = 16'h0003;
  typedef struct packed {
    logic [3:0] fn;
    logic [15:0] addr;
    logic [15:0] dst;
    logic [1:0] bad;
    logic rep;
    logic [7:0] ctrl;
    logic lr;
    logic ur;
    logic dr;
  } row_type;
  // fn addr dst bad(1 crc, 2 start) reply ctrl link user drop
  localparam row_type ROWS [9] = '{
    '{4'h0, 16'h1234, 16'h1234, 2'h0, 1'b1, 8'h00, 1'b1, 1'b0, 1'b0},
    '{4'h1, 16'h1234, 16'h1234, 2'h0, 1'b1, 8'h00, 1'b0, 1'b1, 1'b0},
    '{4'h9, 16'h1234, 16'h1234, 2'h0, 1'b1, 8'h0b, 1'b0, 1'b0, 1'b0},
    '{4'h2, 16'h1234, 16'h1234, 2'h0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b1},
    '{4'h9, 16'h1234, 16'h1235, 2'h0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b1},
    '{4'h0, 16'h1234, 16'h1234, 2'h1, 1'b0, 8'h00, 1'b0, 1'b0, 1'b1},
    '{4'h9, 16'h1234, 16'h1234, 2'h2, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0},
    '{4'h9, 16'hfffe, 16'hfffe, 2'h0, 1'b1, 8'h0b, 1'b0, 1'b0, 1'b0},
    '{4'h9, 16'hffff, 16'hffff, 2'h0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b1}};
  logic mclk, rst_n, m_tx, line, tx_out, tx_oe_n, out_valid, out_ready;
  logic seq_gap, frame_drop, link_reset, user_reset, ready_en;
  logic [15:0] link_addr;
  dnp3_pkg::seg_byte_type out_item;
  dnp3_pkg::seg_byte_type items[$];
  logic [7:0] fr[$];
  int n_mismatch = 0, tests_run = 0, n_lr = 0, n_ur = 0, n_dr = 0, n_gap = 0;

  // shared half-duplex wire: whoever enables drives it
  assign line = (tx_oe_n === 1'b0) ? tx_out : m_tx;

  dnp3_link_transport_slave #(.BIT_CYCLES(16), .FIFO_DEPTH(16))
    dnp3_link_transport_slave_i (.mclk(mclk), .rst_n(rst_n),
    .link_addr(link_addr), .rx_in(line), .tx_out(tx_out),
    .tx_oe_n(tx_oe_n), .out_valid(out_valid), .out_ready(out_ready),
    .out_item(out_item), .seq_gap(seq_gap), .frame_drop(frame_drop),
    .link_reset(link_reset), .user_reset(user_reset));
  dnp3_master_model #(.BIT_CYCLES(16)) dnp3_master_model_i (.mclk(mclk),
    .line_in(line), .tx_oe_n(tx_oe_n), .line_out(m_tx));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // consumer stalls every other cycle so the fifo sees back-pressure
  always @(negedge mclk) out_ready <= ready_en & ~out_ready;

  // pulse counters and fifo capture
  always @(posedge mclk) begin
    if (link_reset === 1'b1) n_lr++;
    if (user_reset === 1'b1) n_ur++;
    if (frame_drop === 1'b1) n_dr++;
    if (seq_gap === 1'b1) n_gap++;
    if (out_valid === 1'b1 && out_ready === 1'b1) items.push_back(out_item);
    if (rst_n && tx_oe_n === 1'b1)
      check("tx_idle", 16'h1, 16'(tx_out));
  end

  task automatic check(input string name, input logic [15:0] exp,
                       input logic [15:0] seen);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // reflected crc, init zero, complemented, low byte first
  task automatic add_crc(input int from);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = from; i < fr.size(); i++) begin
      c = c ^ {8'h00, fr[i]};
      for (int k = 0; k < 8; k++)
        c = c[0] ? ((c >> 1) ^ dnp3_pkg::CRC_POLY) : (c >> 1);
    end
    c = ~c;
    fr.push_back(c[7:0]);
    fr.push_back(c[15:8]);
  endtask

  task automatic add_hdr(input logic [7:0] len, input logic [7:0] ctrl,
                         input logic [15:0] dst, input logic [15:0] src);
    fr.delete();
    fr = '{8'h05, 8'h64, len, ctrl, dst[7:0], dst[15:8], src[7:0], src[15:8]};
    add_crc(0);
  endtask

  // transport byte then user bytes, cut into 16-octet blocks
  task automatic add_data(input logic [7:0] tp, input int n,
                          input logic [7:0] base);
    int cnt;
    cnt = 0;
    for (int i = 0; i <= n; i++) begin
      fr.push_back(i == 0 ? tp : base + 8'(i - 1));
      cnt++;
      if (cnt == 16 || i == n) begin
        add_crc(fr.size() - cnt);
        cnt = 0;
      end
    end
  endtask

  task automatic send_req;
    dnp3_master_model_i.got.delete();
    dnp3_master_model_i.send_frame(fr);
  endtask

  task automatic expect_reply(input logic rep, input logic [7:0] ctrl);
    if (rep) begin
      for (int i = 0; i < 3000 && dnp3_master_model_i.got.size() < 10; i++)
        @(posedge mclk);
    end else
      repeat (600) @(posedge mclk);
    add_hdr(8'h05, ctrl, REQ_SRC, link_addr);
    check("reply_len", rep ? 16'h000a : 16'h0000,
          16'(dnp3_master_model_i.got.size()));
    for (int i = 0; i < dnp3_master_model_i.got.size() && i < 10; i++)
      check("reply_byte", fr[i], dnp3_master_model_i.got[i]);
    check("stop_bit", 16'h0, 16'(dnp3_master_model_i.stop_bad));
  endtask

  task automatic run_row(input int r);
    row_type w;
    int lr, ur, dr;
    w = ROWS[r];
    @(negedge mclk);
    link_addr = w.addr;
    lr = n_lr;
    ur = n_ur;
    dr = n_dr;
    add_hdr(8'h05, 8'hc0 | {4'h0, w.fn}, w.dst, REQ_SRC);
    if (w.bad == 2'h1) fr[8] = ~fr[8];
    if (w.bad == 2'h2) fr[0] = 8'h06;
    send_req();
    expect_reply(w.rep, w.ctrl);
    check("link_reset", 16'(w.lr), 16'(n_lr - lr));
    check("user_reset", 16'(w.ur), 16'(n_ur - ur));
    check("frame_drop", 16'(w.dr), 16'(n_dr - dr));
  endtask

  task automatic data_frame(input logic [3:0] fn, input logic [7:0] tp,
                            input int n, input logic [7:0] base,
                            input logic bad, input int gap);
    int g, d;
    g = n_gap;
    d = n_dr;
    items.delete();
    add_hdr(8'(6 + n), 8'hc0 | {4'h0, fn}, link_addr, REQ_SRC);
    add_data(tp, n, base);
    if (bad) fr[fr.size() - 1] = ~fr[fr.size() - 1];
    send_req();
    expect_reply(fn == 4'h3 && !bad, 8'h00);
    if (!ready_en) begin
      check("fifo_full", 16'h1, 16'(out_valid));
      ready_en = 1'b1;
    end
    for (int i = 0; i < 600 && items.size() < n; i++) @(posedge mclk);
    check("frame_drop", 16'(bad), 16'(n_dr - d));
    check("seq_gap", 16'(gap), 16'(n_gap - g));
    if (!bad) begin
      check("items", 16'(n), 16'(items.size()));
      foreach (items[i])
        check("item", {4'h0, tp[6], tp[7], i == 0, i == n - 1,
              base + 8'(i)}, 16'(items[i]));
    end
  endtask

  task automatic reset_check;
    check("rst_tx", 16'h1, 16'(tx_out));
    check("rst_oe", 16'h1, 16'(tx_oe_n));
    check("rst_valid", 16'h0, 16'(out_valid));
  endtask

  initial begin
    rst_n = 1'b0;
    link_addr = 16'h1234;
    ready_en = 1'b0;
    out_ready = 1'b0;
    repeat (10) @(negedge mclk);
    reset_check();
    rst_n = 1'b1;
    $display("test reset done");
    // reset link then reset user come first, as a master should
    for (int r = 0; r < 9; r++) run_row(r);
    $display("test link_functions done");
    @(negedge mclk);
    link_addr = 16'h1234;
    ready_en = 1'b1;
    data_frame(4'h3, 8'hc0, 20, 8'h10, 1'b0, 0);
    ready_en = 1'b0;
    data_frame(4'h4, 8'hc1, 17, 8'h40, 1'b0, 0);
    $display("test data_fifo done");
    data_frame(4'h4, 8'h42, 3, 8'h70, 1'b0, 0);
    data_frame(4'h4, 8'h04, 2, 8'h80, 1'b0, 1);
    data_frame(4'h4, 8'h85, 2, 8'h90, 1'b0, 0);
    data_frame(4'h3, 8'hc6, 20, 8'ha0, 1'b1, 0);
    repeat (300) @(posedge mclk);
    $display("test transport done");
    // second reset while a reply is on the wire
    add_hdr(8'h05, 8'hc9, link_addr, REQ_SRC);
    send_req();
    for (int i = 0; i < 200 && tx_oe_n !== 1'b0; i++) @(negedge mclk);
    repeat (40) @(negedge mclk);
    rst_n = 1'b0;
    @(negedge mclk);
    reset_check();
    rst_n = 1'b1;
    repeat (400) @(posedge mclk);
    run_row(2);
    $display("test mid_reset done");
    end_sim();
  end

  // watchdog sized well above the expected run of about 58k cycles
  initial begin
    repeat (95000) @(posedge mclk);
    n_mismatch++;
    end_sim();
  end
endmodule // tb_top
